// [logic/capture_edge.sv]
// Capture source selection, synchronisation and edge detection.
`timescale 1ns/1ps
module capture_edge
   import ctr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input ctr_pkg::cap_src_t src,
   input wire logic [1:0] src_sel,
   input wire logic [1:0] edge_sel,
   output logic cap_pulse
);
   cap_state_t st;
   cap_state_t next_st;
   logic level;

   // ----------------------------------------------------------------
   // Source selection and edge detection
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.sync_pa2 = {st.sync_pa2[0], src.pa2}; // [RQ25]
      next_st.sync_pa3 = {st.sync_pa3[0], src.pa3}; // [RQ25]
      unique case (src_sel_t'(src_sel)) // [RQ16]
         SRC_PA2: level = st.sync_pa2[1];
         SRC_PA3: level = st.sync_pa3[1];
         SRC_16K: level = src.tick_16khz;
         SRC_1K: level = src.tick_1khz;
      endcase
      next_st.prev = level;
      unique case (edge_sel_t'(edge_sel)) // [RQ17]
         EDGE_OFF: next_st.pulse = 1'b0;
         EDGE_RISE: next_st.pulse = level && !st.prev;
         EDGE_FALL: next_st.pulse = !level && st.prev;
         EDGE_BOTH: next_st.pulse = level != st.prev;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign cap_pulse = st.pulse;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_edge_off_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RQ17]
      edge_sel == EDGE_OFF |=> !cap_pulse) else $error("Capture pulse while capture disabled.");
   a_pa2_rise_seen: assert property (@(posedge clk) disable iff (!rst_n) // [RQ25]
      (src_sel == SRC_PA2 && edge_sel == EDGE_RISE && $rose(st.sync_pa2[1])) |=> cap_pulse)
      else $error("Rising port A edge not captured.");
endmodule

// [logic/counter_pwm_capture_unit.sv]
// Four 8-bit counters with cascading, PWM and capture, behind an AHB-Lite register slave.
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module counter_pwm_capture_unit
   import ctr_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input ctr_pkg::ahb_in_t ahb,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [3:0] count_tick,
   input wire logic [3:2] port_a_lines,
   input wire logic tick_1khz,
   input wire logic tick_16khz,
   output logic [1:0] port_b_lines,
   output logic [3:0] counter_event
);
   logic rst_meta;
   logic rst_n;
   ctr_state_t st;
   ctr_state_t next_st;
   cap_src_t cap_src;
   logic cap_pulse;
   logic cap_on;
   logic accept;
   logic [1:0] wave;
   logic [1:0][15:0] pair_value;
   logic [1:0][15:0] pair_code;
   logic [1:0] pair_tick;
   logic [16:0] r;
   logic [15:0] mask;
   logic [7:0] wdata;
   logic casc;
   logic wrap;
   int lo;
   int idx;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // Capture source and PWM slices
   // ----------------------------------------------------------------
   assign cap_src = '{tick_1khz: tick_1khz, tick_16khz: tick_16khz, pa2: port_a_lines[2], pa3: port_a_lines[3]};
   assign cap_on = st.cfg_b[CFGB_EDGE_LSB +: 2] != EDGE_OFF;

   capture_edge i_capture_edge (
      .clk(clk),
      .rst_n(rst_n),
      .src(cap_src),
      .src_sel(st.cfg_b[CFGB_SRC_LSB +: 2]),
      .edge_sel(st.cfg_b[CFGB_EDGE_LSB +: 2]),
      .cap_pulse(cap_pulse)
   );

   for (genvar p = 0; p < 2; p++)
   begin : g_pwm
      assign pair_value[p] = st.cfg_a[CFGA_CASC_LSB + p] ? {st.value[2 * p + 1], st.value[2 * p]}
                                                          : {BYTE_ZERO, st.value[2 * p]}; // [RQ13]
      assign pair_code[p] = st.cfg_a[CFGA_CASC_LSB + p] ? {st.cmp[2 * p + 1], st.cmp[2 * p]}
                                                         : {BYTE_ZERO, st.cmp[2 * p]};
      assign pair_tick[p] = count_tick[2 * p];
      pwm_out i_pwm_out (
         .clk(clk),
         .rst_n(rst_n),
         .tick(pair_tick[p]),
         .value(pair_value[p]),
         .code(pair_code[p]),
         .wave(wave[p])
      );
   end

   // ----------------------------------------------------------------
   // Counting, capture and register access
   // ----------------------------------------------------------------
   assign accept = ahb.hsel && ahb.hready && ahb.htrans[1];

   always_comb
   begin
      next_st = st;
      next_st.event_out = 4'h0;
      r = 17'h0_0000;
      mask = WORD_MASK;
      casc = 1'b0;
      wrap = 1'b0;
      lo = 0;
      idx = 0;
      wdata = ahb.hwdata[7:0];
      for (int p = 0; p < 2; p++)
      begin
         lo = 2 * p;
         casc = st.cfg_a[CFGA_CASC_LSB + p];
         if (casc)
         begin
            // The pair steps on the low counter's tick and runs on the high counter's bit.
            mask = pwm_on(st.cfg_a, lo) ? res_mask(st.cfg_b[CFGB_RES_LSB + 2 * p +: 2]) : WORD_MASK; // [RQ13]
            wrap = pwm_on(st.cfg_a, lo) || (p == 0 && cap_on); // [RQ10] [RQ18]
            r = step_count({st.value[lo + 1], st.value[lo]}, {st.cmp[lo + 1], st.cmp[lo]},
                           eff_up(st.cfg_a, lo), wrap, mask); // [RQ2] [RQ3]
            if (st.run[lo + 1] && count_tick[lo]) // [RQ24] [RQ7]
            begin
               next_st.value[lo + 1] = r[15:8];
               next_st.value[lo] = r[7:0];
               next_st.event_out[lo] = r[16]; // [RQ4] [RQ5]
            end
         end
         else
         begin
            for (int h = 0; h < 2; h++)
            begin
               idx = lo + h;
               wrap = pwm_on(st.cfg_a, idx) || (p == 0 && cap_on); // [RQ10] [RQ18]
               r = step_count({BYTE_ZERO, st.value[idx]}, {BYTE_ZERO, st.cmp[idx]},
                              eff_up(st.cfg_a, idx), wrap, BYTE_MASK); // [RQ1]
               if (st.run[idx] && count_tick[idx]) // [RQ24] [RQ7]
               begin
                  next_st.value[idx] = r[7:0];
                  next_st.event_out[idx] = r[16]; // [RQ4] [RQ5]
               end
            end
         end
      end

      // Shadows are filled on the counter's own tick, so the event lands one or two ticks late.
      if (cap_on)
      begin
         if (st.cfg_a[CFGA_CASC_LSB])
         begin
            if (st.cap_pend[0] && count_tick[0]) // [RQ15] [RQ20]
            begin
               next_st.shadow = {st.value[1], st.value[0]};
               next_st.event_out[1:0] = 2'b11;
               next_st.cap_pend = 2'b00;
            end
         end
         else
         begin
            for (int i = 0; i < 2; i++)
            begin
               if (st.cap_pend[i] && count_tick[i]) // [RQ15] [RQ20] [RQ21]
               begin
                  next_st.shadow[8 * i +: 8] = st.value[i];
                  next_st.event_out[i] = 1'b1;
                  next_st.cap_pend[i] = 1'b0;
               end
            end
         end
         if (cap_pulse)
            next_st.cap_pend = 2'b11; // [RQ16] [RQ22]
      end
      else
         next_st.cap_pend = 2'b00;

      // Bus write data phase; it is applied after counting, so a write beats a same-cycle tick.
      if (st.wr_pend)
      begin
         unique case (st.wr_addr)
            OFF_CNT_A, OFF_CNT_B, OFF_CNT_C, OFF_CNT_D:
            begin
               idx = int'(st.wr_addr[3:2]);
               next_st.cmp[idx] = wdata;
               if (!pwm_on(st.cfg_a, idx) && !(idx < 2 && cap_on)) // [RQ23] [RQ6]
                  next_st.value[idx] = eff_up(st.cfg_a, idx) ? BYTE_ZERO : wdata;
            end
            OFF_MODE_A: next_st.cfg_a = wdata;
            OFF_MODE_B: next_st.cfg_b = wdata; // [RQ19]
            OFF_RUN: next_st.run = wdata[3:0];
            OFF_PORT_B: next_st.latch = wdata[1:0];
            default: next_st.latch = st.latch;
         endcase
      end
      next_st.wr_pend = accept && ahb.hwrite && ahb.haddr[31:8] == WINDOW_HIGH;
      next_st.wr_addr = ahb.haddr[7:0];

      // Read data is registered in the address phase; unmapped words read as zero.
      if (accept && !ahb.hwrite)
      begin
         next_st.rdata = 32'h0000_0000;
         if (ahb.haddr[31:8] == WINDOW_HIGH)
         begin
            unique case (ahb.haddr[7:0])
               OFF_CNT_A: next_st.rdata = {PAD_ZERO, cap_on ? st.shadow[7:0] : st.value[0]}; // [RQ15]
               OFF_CNT_B: next_st.rdata = {PAD_ZERO, cap_on ? st.shadow[15:8] : st.value[1]}; // [RQ15]
               OFF_CNT_C: next_st.rdata = {PAD_ZERO, st.value[2]};
               OFF_CNT_D: next_st.rdata = {PAD_ZERO, st.value[3]};
               OFF_MODE_A: next_st.rdata = {PAD_ZERO, st.cfg_a};
               OFF_MODE_B: next_st.rdata = {PAD_ZERO, st.cfg_b};
               OFF_RUN: next_st.rdata = {PAD_ZERO, 4'h0, st.run};
               OFF_PORT_B: next_st.rdata = {PAD_ZERO, 6'h00, st.latch};
               default: next_st.rdata = 32'h0000_0000;
            endcase
         end
      end

      // PWM overrides the port B latch bit.
      for (int p = 0; p < 2; p++)
         next_st.port_b[p] = st.cfg_a[CFGA_PWM_LSB + p] ? wave[p] : st.latch[p]; // [RQ8]
      next_st.ready = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign hrdata = st.rdata;
   assign hreadyout = st.ready;
   assign hresp = 1'b0;
   assign port_b_lines = st.port_b;
   assign counter_event = st.event_out;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic timer_a;
   logic casc_ab_up;
   assign timer_a = !st.cfg_a[CFGA_CASC_LSB] && !st.cfg_a[CFGA_PWM_LSB] && !cap_on;
   assign casc_ab_up = st.cfg_a[CFGA_CASC_LSB] && !st.cfg_a[CFGA_PWM_LSB] && !cap_on && st.cfg_a[CFGA_DIR_LSB];

   a_run_gate_freeze: assert property (@(posedge clk) disable iff (!rst_n) // [RQ24]
      (!st.cfg_a[CFGA_CASC_LSB] && !st.run[0] && !st.wr_pend) |=> $stable(st.value[0]))
      else $error("Stopped counter A moved.");
   a_up_target_event: assert property (@(posedge clk) disable iff (!rst_n) // [RQ4]
      (timer_a && st.cfg_a[CFGA_DIR_LSB] && st.run[0] && count_tick[0] && !st.wr_pend
       && st.value[0] == st.cmp[0]) |=> (st.value[0] == BYTE_ZERO && counter_event[0]))
      else $error("Upcount terminal did not clear and signal.");
   a_down_zero_reload: assert property (@(posedge clk) disable iff (!rst_n) // [RQ5]
      (timer_a && !st.cfg_a[CFGA_DIR_LSB] && st.run[0] && count_tick[0] && !st.wr_pend
       && st.value[0] == BYTE_ZERO) |=> (st.value[0] == $past(st.cmp[0]) && counter_event[0]))
      else $error("Downcount terminal did not reload and signal.");
   a_up_step_one: assert property (@(posedge clk) disable iff (!rst_n) // [RQ1]
      (timer_a && st.cfg_a[CFGA_DIR_LSB] && st.run[0] && count_tick[0] && !st.wr_pend
       && st.value[0] != st.cmp[0]) |=> (st.value[0] == $past(st.value[0]) + 8'h01 && !counter_event[0]))
      else $error("Upcount did not step by one.");
   a_casc_follow_dir: assert property (@(posedge clk) disable iff (!rst_n) // [RQ3]
      (casc_ab_up && !st.cfg_a[CFGA_DIR_LSB + 1] && st.run[1] && count_tick[0] && !st.wr_pend
       && {st.value[1], st.value[0]} != {st.cmp[1], st.cmp[0]})
      |=> {st.value[1], st.value[0]} == $past({st.value[1], st.value[0]}) + 16'h0001)
      else $error("Cascaded pair ignored counter A direction.");
   a_pwm_no_event: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
      (st.cfg_a[CFGA_PWM_LSB + 1] && st.cfg_a[CFGA_CASC_LSB + 1]) |=> !counter_event[2] && !counter_event[3])
      else $error("PWM pair raised an event.");
   a_pwm_a_quiet: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
      (st.cfg_a[CFGA_PWM_LSB] && !cap_on) |=> !counter_event[0])
      else $error("PWM counter A raised an event.");
   // A code above the resolution maximum is never passed by the masked count.
   a_pwm_over_high: assert property (@(posedge clk) disable iff (!rst_n) // [RQ14]
      (st.cfg_a[CFGA_PWM_LSB] && st.cfg_a[CFGA_CASC_LSB] && count_tick[0]
       && pair_code[0] > res_mask(st.cfg_b[CFGB_RES_LSB +: 2])) |=> wave[0])
      else $error("Over-range PWM code did not hold the wave high.");
   a_pwm_pin_drive: assert property (@(posedge clk) disable iff (!rst_n) // [RQ8]
      st.cfg_a[CFGA_PWM_LSB] |=> port_b_lines[0] == $past(wave[0]))
      else $error("Port B line 0 does not carry the PWM wave.");
   a_latch_pass: assert property (@(posedge clk) disable iff (!rst_n) // [RQ8]
      !st.cfg_a[CFGA_PWM_LSB + 1] |=> port_b_lines[1] == $past(st.latch[1]))
      else $error("Port B line 1 does not carry the latch.");
   a_capture_shadow: assert property (@(posedge clk) disable iff (!rst_n) // [RQ15]
      (cap_on && !st.cfg_a[CFGA_CASC_LSB] && st.cap_pend[0] && count_tick[0])
      |=> (st.shadow[7:0] == $past(st.value[0]) && counter_event[0]))
      else $error("Capture did not fill shadow A with an event.");
   a_capture_pend: assert property (@(posedge clk) disable iff (!rst_n) // [RQ20]
      (cap_on && cap_pulse) |=> st.cap_pend == 2'b11)
      else $error("Capture edge was lost.");
   a_write_up_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RQ23]
      (timer_a && st.cfg_a[CFGA_DIR_LSB] && st.wr_pend && st.wr_addr == OFF_CNT_A)
      |=> (st.value[0] == BYTE_ZERO && st.cmp[0] == $past(ahb.hwdata[7:0])))
      else $error("Upcount write did not clear the count.");

   c_up_terminal: cover property (@(posedge clk) disable iff (!rst_n) timer_a && counter_event[0]);
   c_pwm_high: cover property (@(posedge clk) disable iff (!rst_n) st.cfg_a[CFGA_PWM_LSB] && port_b_lines[0]);
   c_pwm_casc_high: cover property (@(posedge clk) disable iff (!rst_n)
      st.cfg_a[CFGA_PWM_LSB] && st.cfg_a[CFGA_CASC_LSB] && port_b_lines[0]);
   c_capture_casc: cover property (@(posedge clk) disable iff (!rst_n)
      cap_on && st.cfg_a[CFGA_CASC_LSB] && counter_event[1:0] == 2'b11);
endmodule

// [logic/pwm_out.sv]
// PWM comparator with its registered, glitch-free output.
`timescale 1ns/1ps
module pwm_out
   import ctr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [15:0] value,
   input wire logic [15:0] code,
   output logic wave
);
   logic st;
   logic next_st;

   // A code above the resolution maximum can never be passed by the count, so the wave stays high.
   always_comb
   begin
      next_st = st;
      if (tick)
         next_st = value <= code; // [RQ11] [RQ12] [RQ14]
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= 1'b0;
      else
         st <= next_st;
   end

   assign wave = st;

   a_wave_sample: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
      tick |=> wave == ($past(value) <= $past(code))) else $error("PWM wave not sampled from compare.");
   a_wave_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
      !tick |=> $stable(wave)) else $error("PWM wave changed without a counter tick.");
endmodule

// [shared/ctr_pkg.sv]
// Constants, carrier types and helper functions of the counter, PWM and capture unit.
// Contract
// RQ1: Each counter counts up when its direction bit is set, down when cleared.
// RQ2: Mode bit 2 joins A and B, bit 3 joins C and D, into 16 bits.
// RQ3: Cascaded B follows A's direction, cascaded D follows C's direction.
// RQ4: Upcount timer reaching target raises event on next tick and returns to zero.
// RQ5: Downcount timer reaching zero raises event on next tick and reloads load value.
// RQ6: Software configures modes before writing counter values, and writes both cascaded halves.
// RQ7: Re-enabling a timer halted at its terminal count may repeat that event.
// RQ8: Mode bits 0 and 1 put pairs in PWM, overriding port B latch bits.
// RQ9: Software sets port B lines 0 and 1 as digital outputs for PWM.
// RQ10: PWM counters raise no events and wrap freely at zero or the maximum.
// RQ11: Internal PWM is high while count is at most the code, else low.
// RQ12: PWM pin is the internal PWM registered on the counter tick.
// RQ13: Single PWM is 8 bits; cascaded resolution field picks 16, 14, 12 or 10.
// RQ14: Cascaded PWM code above the resolution maximum keeps the output high.
// RQ15: With capture on, reads of A and B return shadows, updated with an event.
// RQ16: Capture source bits 7:6 pick 1 kHz, 16 kHz, port A line 3 or 2.
// RQ17: Capture bits 5:4 pick disabled, rising, falling or both edges.
// RQ18: With capture on, A and B wrap freely, also while generating PWM.
// RQ19: Software changes capture source and edge fields only with counters stopped.
// RQ20: The capture event arrives one or two counter ticks after the edge.
// RQ21: Uncascaded software reads a shadow only after that counter's capture event.
// RQ22: Capture source must stay high and low longer than one counter tick period.
// RQ23: Timer-mode writes set the compare and clear (up) or load (down) the count.
// RQ24: Counters run only with their run bit set; cascaded pairs use B and D.
// RQ25: Port A capture inputs pass a two-stage synchroniser before edge detection.
package ctr_pkg;
   localparam logic [7:0] OFF_CNT_A = 8'h00;
   localparam logic [7:0] OFF_CNT_B = 8'h04;
   localparam logic [7:0] OFF_CNT_C = 8'h08;
   localparam logic [7:0] OFF_CNT_D = 8'h0C;
   localparam logic [7:0] OFF_MODE_A = 8'h10;
   localparam logic [7:0] OFF_MODE_B = 8'h14;
   localparam logic [7:0] OFF_RUN = 8'h18;
   localparam logic [7:0] OFF_PORT_B = 8'h1C;
   localparam logic [23:0] WINDOW_HIGH = 24'h00_0000;
   localparam int CFGA_PWM_LSB = 0;
   localparam int CFGA_CASC_LSB = 2;
   localparam int CFGA_DIR_LSB = 4;
   localparam int CFGB_RES_LSB = 0;
   localparam int CFGB_EDGE_LSB = 4;
   localparam int CFGB_SRC_LSB = 6;
   localparam logic [15:0] BYTE_MASK = 16'h00FF;
   localparam logic [15:0] WORD_MASK = 16'hFFFF;
   localparam logic [15:0] RES16_MASK = 16'hFFFF;
   localparam logic [15:0] RES14_MASK = 16'h3FFF;
   localparam logic [15:0] RES12_MASK = 16'h0FFF;
   localparam logic [15:0] RES10_MASK = 16'h03FF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [23:0] PAD_ZERO = 24'h00_0000;

   typedef enum logic [1:0] {EDGE_OFF = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10, EDGE_BOTH = 2'b11} edge_sel_t;
   typedef enum logic [1:0] {SRC_PA2 = 2'b00, SRC_PA3 = 2'b01, SRC_16K = 2'b10, SRC_1K = 2'b11} src_sel_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_in_t;

   typedef struct packed {
      logic tick_1khz;
      logic tick_16khz;
      logic pa2;
      logic pa3;
   } cap_src_t;

   typedef struct packed {
      logic [3:0][7:0] value;
      logic [3:0][7:0] cmp;
      logic [7:0] cfg_a;
      logic [7:0] cfg_b;
      logic [3:0] run;
      logic [1:0] latch;
      logic [15:0] shadow;
      logic [1:0] cap_pend;
      logic [3:0] event_out;
      logic [1:0] port_b;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic ready;
   } ctr_state_t;

   typedef struct packed {
      logic [1:0] sync_pa2;
      logic [1:0] sync_pa3;
      logic prev;
      logic pulse;
   } cap_state_t;

   // Returns {terminal hit, next count}; free-wrapping counters never hit.
   function automatic logic [16:0] step_count(input logic [15:0] v, input logic [15:0] c, input logic up,
                                              input logic wrap, input logic [15:0] mask);
      logic [16:0] r;
      r = {1'b0, v};
      if (up)
      begin
         if (!wrap && v == c)
            r = {1'b1, 16'h0000};
         else if (v == mask)
            r = {1'b0, 16'h0000};
         else
            r = {1'b0, (v + 16'h0001) & mask};
      end
      else
      begin
         if (v == 16'h0000)
            r = wrap ? {1'b0, mask} : {1'b1, c};
         else
            r = {1'b0, (v - 16'h0001) & mask};
      end
      return r;
   endfunction

   function automatic logic [15:0] res_mask(input logic [1:0] code);
      logic [15:0] m;
      unique case (code)
         2'b11: m = RES16_MASK;
         2'b10: m = RES14_MASK;
         2'b01: m = RES12_MASK;
         2'b00: m = RES10_MASK;
      endcase
      return m;
   endfunction

   function automatic logic eff_up(input logic [7:0] cfg, input int i);
      return cfg[CFGA_CASC_LSB + i / 2] ? cfg[CFGA_DIR_LSB + (i / 2) * 2] : cfg[CFGA_DIR_LSB + i];
   endfunction

   function automatic logic pwm_on(input logic [7:0] cfg, input int i);
      return cfg[CFGA_PWM_LSB + i / 2] && (cfg[CFGA_CASC_LSB + i / 2] || (i % 2 == 0));
   endfunction
endpackage

// [tb/tb_top.sv]
// Self-checking bench for the counter, PWM and capture unit.
`timescale 1ns/1ps
module tb_top;
   import ctr_pkg::*;
   logic clk;
   logic resetn;
   ahb_in_t drv;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [3:0] count_tick;
   logic [3:0] srcs;
   logic [1:0] port_b_lines;
   logic [3:0] counter_event;
   int ev_cnt [4];
   int bad_count;
   int compares;
   int e0;
   int hi;

   // The single slave's hreadyout is the bus hready, so it closes the struct.
   counter_pwm_capture_unit i_counter_pwm_capture_unit (
      .clk(clk), .resetn(resetn), .ahb({drv[$bits(ahb_in_t)-1:1], hreadyout}),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .count_tick(count_tick),
      .port_a_lines(srcs[1:0]), .tick_1khz(srcs[3]), .tick_16khz(srcs[2]),
      .port_b_lines(port_b_lines), .counter_event(counter_event));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      for (int i = 0; i < 4; i++)
         if (counter_event[i] === 1'b1)
            ev_cnt[i] <= ev_cnt[i] + 1;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task report_and_stop;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Holds each phase until hready is sampled high; read data is taken at that same edge.
   task xfer(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [31:0] rd);
      int n;
      n = 0;
      drv.hsel <= 1'b1;
      drv.haddr <= a;
      drv.htrans <= 2'b10;
      drv.hwrite <= wr;
      drv.hsize <= 3'b010;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 20);
      drv.htrans <= 2'b00;
      drv.hwdata <= {24'h00_0000, d};
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata;
      if (n >= 40)
      begin
         bad_count++;
         report_and_stop;
      end
   endtask

   task wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask

   task rchk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      xfer(1'b0, a, 8'h00, x);
      check(x, exp);
   endtask

   // Each tick is followed by idle cycles so that any event lands before the next one.
   task tk(input logic [3:0] m, input int n);
      repeat (n)
      begin
         @(posedge clk) count_tick <= m;
         @(posedge clk) count_tick <= 4'h0;
         repeat (3) @(posedge clk);
      end
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      bad_count++;
      report_and_stop;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      resetn = 1'b0;
      drv = '0;
      count_tick = 4'h0;
      srcs = 4'h0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
      wr(32'h0000_0118, 8'h0F);
      rchk(32'h0000_0118, 32'h0000_0000);
      rchk(32'(OFF_RUN), 32'h0000_0000);
      wr(32'(OFF_MODE_A), 8'h10);
      wr(32'(OFF_CNT_A), 8'h03);
      wr(32'(OFF_RUN), 8'h01);
      tk(4'h1, 3);
      check(ev_cnt[0], 0);
      rchk(32'(OFF_CNT_A), 32'h0000_0003);
      tk(4'h1, 1);
      check(ev_cnt[0], 1);
      rchk(32'(OFF_CNT_A), 32'h0000_0000);
      wr(32'(OFF_CNT_C), 8'h02);
      wr(32'(OFF_RUN), 8'h05);
      tk(4'h4, 2);
      check(ev_cnt[2], 0);
      rchk(32'(OFF_CNT_C), 32'h0000_0000);
      tk(4'h4, 1);
      check(ev_cnt[2], 1);
      rchk(32'(OFF_CNT_C), 32'h0000_0002);
      // B's own direction bit says down here; joined, it must follow A upward.
      wr(32'(OFF_MODE_A), 8'h14);
      wr(32'(OFF_CNT_A), 8'h00);
      wr(32'(OFF_CNT_B), 8'h01);
      wr(32'(OFF_RUN), 8'h02);
      tk(4'h1, 255);
      check(ev_cnt[0], 1);
      rchk(32'(OFF_CNT_B), 32'h0000_0000);
      tk(4'h1, 1);
      rchk(32'(OFF_CNT_A), 32'h0000_0000);
      rchk(32'(OFF_CNT_B), 32'h0000_0001);
      tk(4'h1, 1);
      check(ev_cnt[0], 2);
      check(ev_cnt[1], 0);
      wr(32'(OFF_MODE_A), 8'h10);
      wr(32'(OFF_PORT_B), 8'h02);
      repeat (2) @(posedge clk);
      check(port_b_lines, 2'b10);
      wr(32'(OFF_MODE_A), 8'h11);
      wr(32'(OFF_CNT_A), 8'h01);
      wr(32'(OFF_RUN), 8'h01);
      hi = 0;
      repeat (256)
      begin
         tk(4'h1, 1);
         hi += (port_b_lines === 2'b11);
      end
      check(hi, 2);
      check(ev_cnt[0], 2);
      // Cascaded PWM at 12 bits with a code above 0x0FFF: always high, count wraps at 0x0FFF.
      wr(32'(OFF_MODE_A), 8'h15);
      wr(32'(OFF_MODE_B), 8'h01);
      wr(32'(OFF_CNT_A), 8'hFF);
      wr(32'(OFF_CNT_B), 8'h10);
      wr(32'(OFF_RUN), 8'h02);
      hi = 0;
      repeat (4100)
      begin
         tk(4'h1, 1);
         hi += (port_b_lines[0] === 1'b1);
      end
      check(hi, 4100);
      rchk(32'(OFF_CNT_A), 32'h0000_0004);
      rchk(32'(OFF_CNT_B), 32'h0000_0000);
      wr(32'(OFF_MODE_A), 8'h30);
      wr(32'(OFF_CNT_A), 8'h50);
      wr(32'(OFF_CNT_B), 8'h50);
      wr(32'(OFF_RUN), 8'h01);
      tk(4'h1, 5);
      wr(32'(OFF_RUN), 8'h00);
      e0 = 2;
      // Sources are all low whenever the selection changes, so no false edge appears.
      for (int s = 0; s < 4; s++)
         for (int e = 0; e < 4; e++)
         begin
            wr(32'(OFF_MODE_B), {s[1:0], e[1:0], 4'h0});
            srcs[s] <= 1'b1;
            repeat (5) @(posedge clk);
            tk(4'h1, 1);
            srcs[s] <= 1'b0;
            repeat (5) @(posedge clk);
            tk(4'h1, 1);
            e0 += e[0] + e[1];
            check(ev_cnt[0], e0);
         end
      rchk(32'(OFF_CNT_A), 32'h0000_0005);
      rchk(32'(OFF_CNT_B), 32'h0000_0000);
      check(ev_cnt[1], 0);
      report_and_stop;
   end
endmodule
